// ### rtl/tcp_defines.svh
/*
 Constants of the timing configuration packet handler: framing bytes,
 byte positions, lengths, register offsets, reset values and timing.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

`define TCP_START_BYTE 8'h10
`define TCP_PKT_ID 8'h91
`define TCP_SUB_ID 8'h03
`define TCP_END_BYTE 8'h03
`define TCP_MODE_QUERY 8'h00
`define TCP_MODE_SET 8'h01
`define TCP_MODE_RESP 8'h02
`define TCP_LEN_QUERY 16'h0002
`define TCP_LEN_SET 16'h0013

`define TCP_IDX_PKT 5'h01
`define TCP_IDX_SUB 5'h02
`define TCP_IDX_LEN_HI 5'h03
`define TCP_IDX_LEN_LO 5'h04
`define TCP_IDX_MODE 5'h05
`define TCP_IDX_PAY_FIRST 5'h06
`define TCP_IDX_PAY_LAST 5'h16
`define TCP_IDX_CSUM_QUERY 5'h06
`define TCP_IDX_CSUM_SET 5'h17
`define TCP_IDX_TR1_SET 5'h18
`define TCP_IDX_TR2_SET 5'h19

`define TCP_SRC_LSB 0
`define TCP_SRC_MSB 2
`define TCP_CIVIL_BIT 3
`define TCP_PMODE_LSB 0
`define TCP_PMODE_MSB 2
`define TCP_POL_BIT 3

`define TCP_REG_CTRL 8'h00
`define TCP_REG_STATUS 8'h04
`define TCP_REG_CFG 8'h08
`define TCP_REG_WIDTH 8'h0C
`define TCP_REG_OFS_HI 8'h10
`define TCP_REG_OFS_LO 8'h14
`define TCP_REG_GOOD 8'h18
`define TCP_REG_DROP 8'h1C
`define TCP_CTRL_RESET 32'h0000_0001
`define TCP_CFG_RESET 136'h0

`define TCP_CLK_NS 8
`define TCP_MS_NS 1000000
`define TCP_CYC_PER_MS (`TCP_MS_NS / `TCP_CLK_NS)

`endif

// ### rtl/tcp_fifo.sv
/*
 Byte FIFO in front of the packet parser, valid/ready on both sides.
 Assumes one clock; the drain side may stall at will.
*/
`timescale 1ns/1ns
module tcp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two");
   end
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ff, rd_ff;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
   assign out_valid = wr_ff != rd_ff;
   assign out_data = mem_ff[rd_ff[AW-1:0]];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) wr_ff <= wr_ff + 1'b1;
         if (pop) rd_ff <= rd_ff + 1'b1;
      end
   end

   // Storage carries no reset; only pointers matter
   always_ff @(posedge clk) begin
      if (push) mem_ff[wr_ff[AW-1:0]] <= in_data;
   end
endmodule : tcp_fifo

// ### rtl/tcp_handler.sv
/*
 Timing configuration packet handler: parses query and set packets from
 the command byte stream, answers with response packets, keeps the active
 configuration and drives the pulse generator. Avalon-MM register slave.
 Assumes bytes arrive already de-escaped, one per handshake, on clk.
*/
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "tcp_defines.svh"
// What this block does
// - Packets start 0x10, packet id 0x91, subpacket id 0x03.
// - Bytes 3-4 hold length of mode, payload and checksum.
// - Checksum is followed by trailer bytes 0x10 then 0x03.
// - Every query or set gets a mode 2 response with active configuration.
// - Payload: bases 6,7, pulse mode 8, reserved 9-12, width 13-14, offset 15-22.
// - Low three bits of each base byte pick the constellation.
// - Bit 3 of each base byte selects civil time from that constellation.
// - Pulse mode low bits: off, always, with fix, when timing valid.
// - Pulse mode bit 3 picks positive or negative pulse polarity.
// - Pulse width field is the pulse duration in milliseconds.
// - Pulse offset is a double-precision shift in seconds.
module tcp_handler
   import tcp_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int CYC_PER_MS = `TCP_CYC_PER_MS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic sec_tick,
   input wire logic fix_valid,
   input wire logic timing_valid,
   output tcp_cfg_t cfg_out,
   output tcp_base_t time_base_sel,
   output tcp_base_t pulse_base_sel,
   output logic cfg_updated,
   output logic pulse_out
);
   if (FIFO_DEPTH < 2) begin : g_bad_fifo
      $error("FIFO_DEPTH too small");
   end

   // Response byte at index idx, offset payload bytes MSB first
   function automatic logic [7:0] resp_byte(input logic [4:0] idx,
                                            input logic [135:0] cfg,
                                            input logic [7:0] csum);
      logic [7:0] sh;
      logic [135:0] v;
      sh = 8'd22 - {3'b000, idx};
      v = cfg >> {sh, 3'b000};
      unique case (idx)
         5'd0: resp_byte = `TCP_START_BYTE;
         5'd1: resp_byte = `TCP_PKT_ID;
         5'd2: resp_byte = `TCP_SUB_ID;
         5'd3: resp_byte = 8'(`TCP_LEN_SET >> 8);
         5'd4: resp_byte = 8'(`TCP_LEN_SET);
         5'd5: resp_byte = `TCP_MODE_RESP;
         `TCP_IDX_CSUM_SET: resp_byte = csum;
         `TCP_IDX_TR1_SET: resp_byte = `TCP_START_BYTE;
         `TCP_IDX_TR2_SET: resp_byte = `TCP_END_BYTE;
         default: resp_byte = v[7:0];
      endcase
   endfunction : resp_byte

   function automatic logic [31:0] bump(input logic [31:0] c);
      bump = (c == 32'hFFFF_FFFF) ? c : c + 32'h0000_0001;
   endfunction : bump

   // Byte FIFO ahead of the parser
   logic in_valid;
   logic [7:0] in_byte;
   logic in_ready;
   tcp_fifo #(
      .W(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(rx_valid),
      .in_data(rx_data),
      .in_ready(rx_ready),
      .out_valid(in_valid),
      .out_data(in_byte),
      .out_ready(in_ready)
   );

   tcp_state_t state_ff, nxt_state;
   logic [4:0] idx_ff, nxt_idx;
   logic [7:0] csum_ff, nxt_csum;
   logic [15:0] len_ff, nxt_len;
   logic set_ff, nxt_set;
   logic [135:0] shd_ff, nxt_shd;
   tcp_cfg_t cfg_ff;
   logic [7:0] tx_data_ff, nxt_tx_data;
   logic tx_valid_ff, nxt_tx_valid;
   logic commit, drop, good;
   logic [31:0] ctrl_ff, good_cnt_ff, drop_cnt_ff;

   wire parse_en = ctrl_ff[0];
   // Parser stalls while sending or disabled, so the FIFO fills
   assign in_ready = parse_en & (state_ff != TCP_SEND);
   wire take = in_valid & in_ready;
   wire tx_take = tx_valid_ff & tx_ready;
   wire [4:0] csum_idx = set_ff ? `TCP_IDX_CSUM_SET : `TCP_IDX_CSUM_QUERY;
   wire [4:0] tr1_idx = csum_idx + 5'd1;
   wire [4:0] tr2_idx = csum_idx + 5'd2;
   wire in_csum_span = (idx_ff <= `TCP_IDX_MODE) | (idx_ff < csum_idx);
   wire mode_q_ok = (in_byte == `TCP_MODE_QUERY) & (len_ff == `TCP_LEN_QUERY);
   wire mode_s_ok = (in_byte == `TCP_MODE_SET) & (len_ff == `TCP_LEN_SET);
   wire is_payload = set_ff & (idx_ff >= `TCP_IDX_PAY_FIRST) &
                     (idx_ff <= `TCP_IDX_PAY_LAST);
   wire [7:0] pay_sh = 8'd22 - {3'b000, idx_ff};
   wire [135:0] pay_mask = 136'hFF << {pay_sh, 3'b000};
   wire [135:0] pay_data = {128'h0, in_byte} << {pay_sh, 3'b000};

   always_comb begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_csum = csum_ff;
      nxt_len = len_ff;
      nxt_set = set_ff;
      nxt_shd = shd_ff;
      nxt_tx_data = tx_data_ff;
      nxt_tx_valid = tx_valid_ff;
      commit = 1'b0;
      drop = 1'b0;
      good = 1'b0;
      unique case (state_ff)
         TCP_HUNT: begin
            if (take && in_byte == `TCP_START_BYTE) begin
               nxt_state = TCP_RECV;
               nxt_idx = `TCP_IDX_PKT;
               nxt_csum = 8'h00;
               nxt_set = 1'b0;
            end
         end
         TCP_RECV: begin
            if (take) begin
               nxt_idx = idx_ff + 5'd1;
               if (in_csum_span) nxt_csum = csum_ff ^ in_byte;
               if (idx_ff == `TCP_IDX_PKT) begin
                  drop = in_byte != `TCP_PKT_ID;
               end else if (idx_ff == `TCP_IDX_SUB) begin
                  drop = in_byte != `TCP_SUB_ID;
               end else if (idx_ff == `TCP_IDX_LEN_HI) begin
                  nxt_len = {in_byte, len_ff[7:0]};
               end else if (idx_ff == `TCP_IDX_LEN_LO) begin
                  nxt_len = {len_ff[15:8], in_byte};
               end else if (idx_ff == `TCP_IDX_MODE) begin
                  nxt_set = mode_s_ok;
                  drop = !(mode_q_ok | mode_s_ok);
               end else if (idx_ff == csum_idx) begin
                  drop = in_byte != csum_ff;
               end else if (idx_ff == tr1_idx) begin
                  drop = in_byte != `TCP_START_BYTE;
               end else if (idx_ff == tr2_idx) begin
                  drop = in_byte != `TCP_END_BYTE;
                  good = !drop;
               end else if (is_payload) begin
                  nxt_shd = (shd_ff & ~pay_mask) | pay_data;
               end
               if (drop) begin
                  nxt_state = TCP_HUNT;
               end else if (good) begin
                  // Response reflects the newly committed set values
                  commit = set_ff;
                  nxt_state = TCP_SEND;
                  nxt_idx = 5'd0;
                  nxt_csum = 8'h00;
                  nxt_tx_valid = 1'b1;
                  nxt_tx_data = `TCP_START_BYTE;
               end
            end
         end
         TCP_SEND: begin
            if (tx_take) begin
               if (idx_ff >= `TCP_IDX_PKT && idx_ff < `TCP_IDX_CSUM_SET) begin
                  nxt_csum = csum_ff ^ tx_data_ff;
               end
               if (idx_ff == `TCP_IDX_TR2_SET) begin
                  nxt_state = TCP_HUNT;
                  nxt_tx_valid = 1'b0;
               end else begin
                  nxt_idx = idx_ff + 5'd1;
                  nxt_tx_data = resp_byte(idx_ff + 5'd1,
                     commit ? shd_ff : cfg_ff, nxt_csum);
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= TCP_HUNT;
         idx_ff <= '0;
         csum_ff <= '0;
         len_ff <= '0;
         set_ff <= 1'b0;
         shd_ff <= '0;
         tx_data_ff <= '0;
         tx_valid_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         csum_ff <= nxt_csum;
         len_ff <= nxt_len;
         set_ff <= nxt_set;
         shd_ff <= nxt_shd;
         tx_data_ff <= nxt_tx_data;
         tx_valid_ff <= nxt_tx_valid;
      end
   end

   // Active configuration, replaced whole so fields never mix
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_ff <= tcp_cfg_t'(`TCP_CFG_RESET);
         cfg_updated <= 1'b0;
      end else begin
         cfg_updated <= commit;
         if (commit) cfg_ff <= tcp_cfg_t'(shd_ff);
      end
   end

   assign tx_valid = tx_valid_ff;
   assign tx_data = tx_data_ff;
   // Offset stays in double format; the time core converts it
   assign cfg_out = cfg_ff;
   assign time_base_sel.source = cfg_ff.time_base[`TCP_SRC_MSB:`TCP_SRC_LSB];
   assign time_base_sel.civil_time_select = cfg_ff.time_base[`TCP_CIVIL_BIT];
   assign pulse_base_sel.source =
      cfg_ff.pulse_time_reference[`TCP_SRC_MSB:`TCP_SRC_LSB];
   assign pulse_base_sel.civil_time_select =
      cfg_ff.pulse_time_reference[`TCP_CIVIL_BIT];

   tcp_pulse #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_pulse (
      .clk(clk),
      .resetn(resetn),
      .sec_tick(sec_tick),
      .fix_valid(fix_valid),
      .timing_valid(timing_valid),
      .pulse_mode_byte(cfg_ff.pulse_mode_byte),
      .pulse_width_ms(cfg_ff.pulse_width_ms),
      .pulse_out(pulse_out)
   );

   // Register slave: one wait cycle, then answer
   logic ack_ff;
   logic [31:0] rdata_ff;
   wire req = (avs_read | avs_write) & !ack_ff;
   wire wr_ctrl = avs_write & ack_ff & (avs_address == `TCP_REG_CTRL);
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   logic [31:0] rd_mux;
   assign avs_waitrequest = (avs_read | avs_write) & !ack_ff;
   assign avs_readdata = rdata_ff;

   always_comb begin
      unique case (avs_address)
         `TCP_REG_CTRL: rd_mux = ctrl_ff;
         `TCP_REG_STATUS: rd_mux = {27'h0, cfg_updated, state_ff, parse_en};
         `TCP_REG_CFG: rd_mux = {8'h00, cfg_ff.time_base, cfg_ff.pulse_time_reference,
                                 cfg_ff.pulse_mode_byte};
         `TCP_REG_WIDTH: rd_mux = {16'h0000, cfg_ff.pulse_width_ms};
         `TCP_REG_OFS_HI: rd_mux = cfg_ff.pulse_offset_seconds[63:32];
         `TCP_REG_OFS_LO: rd_mux = cfg_ff.pulse_offset_seconds[31:0];
         `TCP_REG_GOOD: rd_mux = good_cnt_ff;
         `TCP_REG_DROP: rd_mux = drop_cnt_ff;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_ff <= 1'b0;
         rdata_ff <= '0;
         ctrl_ff <= `TCP_CTRL_RESET;
      end else begin
         ack_ff <= req;
         if (req && avs_read) rdata_ff <= rd_mux;
         if (wr_ctrl) ctrl_ff <= (ctrl_ff & ~be_mask) | (avs_writedata & be_mask & 32'h1);
      end
   end

   // Saturating counters of answered and dropped packets
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         good_cnt_ff <= '0;
         drop_cnt_ff <= '0;
      end else begin
         if (good) good_cnt_ff <= bump(good_cnt_ff);
         if (drop) drop_cnt_ff <= bump(drop_cnt_ff);
      end
   end

   sequence s_resp_head;
      tx_valid && tx_data == `TCP_START_BYTE && idx_ff == 5'd0;
   endsequence

   chk_start_byte_hunt: assert property (@(posedge clk) disable iff (!resetn)
      (state_ff == TCP_HUNT && take && in_byte != `TCP_START_BYTE) |=> state_ff == TCP_HUNT)
      else $error("left hunt without start byte");
   chk_bad_id_drop: assert property (@(posedge clk) disable iff (!resetn)
      (state_ff == TCP_RECV && take && idx_ff == 5'd1 && in_byte != `TCP_PKT_ID)
      |=> state_ff == TCP_HUNT) else $error("bad packet id kept");
   chk_len_mode_pair: assert property (@(posedge clk) disable iff (!resetn)
      (state_ff == TCP_RECV && take && idx_ff == 5'd5 && in_byte == `TCP_MODE_SET
       && len_ff != `TCP_LEN_SET) |=> state_ff == TCP_HUNT)
      else $error("length mismatch accepted");
   chk_trailer_drop: assert property (@(posedge clk) disable iff (!resetn)
      (state_ff == TCP_RECV && take && idx_ff == tr2_idx && in_byte != `TCP_END_BYTE)
      |=> state_ff == TCP_HUNT && !tx_valid) else $error("bad trailer answered");
   chk_resp_start: assert property (@(posedge clk) disable iff (!resetn)
      $rose(tx_valid) |-> s_resp_head) else $error("response not framed");
   chk_resp_mode: assert property (@(posedge clk) disable iff (!resetn)
      (tx_valid && idx_ff == `TCP_IDX_MODE) |-> tx_data == `TCP_MODE_RESP)
      else $error("response mode not 2");
   chk_resp_trailer: assert property (@(posedge clk) disable iff (!resetn)
      (tx_take && idx_ff == `TCP_IDX_TR2_SET) |-> tx_data == `TCP_END_BYTE ##1 !tx_valid)
      else $error("response trailer wrong");
   chk_set_commit: assert property (@(posedge clk) disable iff (!resetn)
      commit |=> cfg_ff == tcp_cfg_t'($past(shd_ff)) && cfg_updated)
      else $error("set not committed");
   chk_query_keeps: assert property (@(posedge clk) disable iff (!resetn)
      (good && !set_ff) |=> $stable(cfg_ff)) else $error("query changed config");
   chk_csum_drop: assert property (@(posedge clk) disable iff (!resetn)
      (state_ff == TCP_RECV && take && idx_ff == csum_idx && idx_ff > 5'd5
       && in_byte != csum_ff) |=> state_ff == TCP_HUNT) else $error("bad checksum kept");
   chk_bus_answer: assert property (@(posedge clk) disable iff (!resetn)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest) else $error("bus answer late");
endmodule : tcp_handler

// ### rtl/tcp_pkg.sv
/*
 Types of the timing configuration packet handler.
 Assumes tcp_defines.svh for all numeric constants.
*/
package tcp_pkg;

   typedef enum logic [2:0] {
      TCP_HUNT = 3'b001,
      TCP_RECV = 3'b010,
      TCP_SEND = 3'b100
   } tcp_state_t;

   // Field order equals wire order, most significant byte first
   typedef struct packed {
      logic [7:0] time_base;
      logic [7:0] pulse_time_reference;
      logic [7:0] pulse_mode_byte;
      logic [31:0] reserved_word;
      logic [15:0] pulse_width_ms;
      logic [63:0] pulse_offset_seconds;
   } tcp_cfg_t;

   typedef struct packed {
      logic [2:0] source;
      logic civil_time_select;
   } tcp_base_t;

endpackage : tcp_pkg

// ### rtl/tcp_pulse.sv
/*
 Pulse generator steered by the pulse mode byte and pulse width.
 Assumes sec_tick is a one-cycle pulse once per second from the time core.
*/
`timescale 1ns/1ns
`include "tcp_defines.svh"
module tcp_pulse
   import tcp_pkg::*;
#(
   parameter int CYC_PER_MS = `TCP_CYC_PER_MS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sec_tick,
   input wire logic fix_valid,
   input wire logic timing_valid,
   input wire logic [7:0] pulse_mode_byte,
   input wire logic [15:0] pulse_width_ms,
   output logic pulse_out
);
   if (CYC_PER_MS < 1) begin : g_bad_ms
      $error("CYC_PER_MS must be positive");
   end
   logic [31:0] cyc_ff;
   logic [15:0] ms_left_ff;
   logic active_ff;
   wire [2:0] pmode = pulse_mode_byte[`TCP_PMODE_MSB:`TCP_PMODE_LSB];
   wire allowed = (pmode == 3'd1) | ((pmode == 3'd2) & fix_valid) |
                  ((pmode == 3'd3) & timing_valid);
   wire start = sec_tick & allowed & (pulse_width_ms != 16'h0000);
   wire ms_done = cyc_ff == 32'(CYC_PER_MS - 1);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         active_ff <= 1'b0;
         cyc_ff <= '0;
         ms_left_ff <= '0;
      end else if (start) begin
         active_ff <= 1'b1;
         cyc_ff <= '0;
         ms_left_ff <= pulse_width_ms;
      end else if (active_ff) begin
         cyc_ff <= ms_done ? '0 : cyc_ff + 1'b1;
         if (ms_done) ms_left_ff <= ms_left_ff - 1'b1;
         if (ms_done && ms_left_ff == 16'h0001) active_ff <= 1'b0;
      end
   end

   // Idle level follows polarity so a negative pulse idles high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) pulse_out <= 1'b0;
      else pulse_out <= active_ff ^ pulse_mode_byte[`TCP_POL_BIT];
   end

   chk_pulse_off_mode: assert property (@(posedge clk) disable iff (!resetn)
      (pmode == 3'd0) |-> !start) else $error("pulse started while off");
   chk_pulse_width_ms: assert property (@(posedge clk) disable iff (!resetn)
      start |=> active_ff && ms_left_ff == $past(pulse_width_ms))
      else $error("pulse width not loaded");
endmodule : tcp_pulse

// ### sim/tcp_host.sv
/*
 Host model: frames command packets, offers bytes, sinks responses.
 Assumes the handler's valid/ready byte streams on one clock.
*/
`timescale 1ns/1ns
module tcp_host (
   input wire logic clk,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic slow = 1'b0;
   logic hold = 1'b0;
   logic [7:0] pk[$];
   logic [7:0] got[$];
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   // Slow mode stalls every other cycle
   always @(posedge clk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      tx_ready <= !hold && !(slow && tx_ready);
   end
   task build(input logic [7:0] m, input logic [135:0] c);
      logic [7:0] cs;
      pk = {8'h10, 8'h91, 8'h03, 8'h00, (m == 8'h00) ? 8'h02 : 8'h13, m};
      if (m != 8'h00) for (int i = 16; i >= 0; i--) pk.push_back(c[i*8 +: 8]);
      cs = 8'h00;
      for (int i = 1; i < pk.size(); i++) cs ^= pk[i];
      pk.push_back(cs);
      pk.push_back(8'h10);
      pk.push_back(8'h03);
   endtask : build
   // Held until rx_ready reads high after an edge, at most 300 cycles; idle data inverted so stale bytes never look valid
   task send_pkt();
      int n;
      for (int i = 0; i < pk.size(); i++) begin
         rx_valid <= 1'b1;
         rx_data <= pk[i];
         n = 0;
         do begin @(posedge clk); n++; end while (rx_ready !== 1'b1 && n < 300);
      end
      rx_valid <= 1'b0;
      rx_data <= ~pk[pk.size()-1];
   endtask : send_pkt
endmodule : tcp_host

// ### sim/timing_config_packet_handler_tb.sv
/*
 Self-checking bench of the packet handler: packet table, registers,
 pulse output and FIFO back-pressure. Assumes tcp_host as the far side.
*/
`timescale 1ns/1ns
module timing_config_packet_handler_tb
   import tcp_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic rx_valid, rx_ready, tx_valid, tx_ready, sec_tick = 1'b0, cfg_updated;
   logic fix_valid = 1'b0, timing_valid = 1'b0;
   logic [3:0] be = 4'hF;
   logic [7:0] rx_data, tx_data, avs_address = 8'h00;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, pulse_out;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
   tcp_cfg_t cfg_out, cur = '0;
   tcp_base_t time_base_sel, pulse_base_sel;
   int bad_count = 0, check_count = 0, cyc = 0, n, upd_count = 0;
   logic ok;
   // Rows: mode, corrupted byte index (0 none), use second config
   int md[8] = '{0, 1, 1, 3, 1, 0, 1, 0};
   int ci[8] = '{0, 0, 23, 0, 4, 8, 1, 0};
   int ub[8] = '{0, 0, 1, 1, 1, 0, 1, 0};
   localparam tcp_cfg_t CFG_A = {8'h0B, 8'h02, 8'h09, 32'hFFFF_FFF0, 16'h0002,
                                 64'h3FF0_0000_0000_0000};
   localparam tcp_cfg_t CFG_B = {8'h01, 8'h03, 8'h01, 32'h0000_0000, 16'h00C8, 64'h0};
   // Pulse only when timing valid, positive, one millisecond
   localparam tcp_cfg_t CFG_C = {8'h00, 8'h00, 8'h03, 32'h0000_0000, 16'h0001, 64'h0};
   always #4 clk = ~clk;
   tcp_host i_host (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   // Short millisecond keeps the pulse check brief
   tcp_handler #(.CYC_PER_MS(4)) i_dut (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sec_tick(sec_tick),
      .fix_valid(fix_valid), .timing_valid(timing_valid), .cfg_out(cfg_out),
      .time_base_sel(time_base_sel), .pulse_base_sel(pulse_base_sel),
      .cfg_updated(cfg_updated), .pulse_out(pulse_out));
   always @(posedge clk) if (cfg_updated === 1'b1) upd_count++;
   task conclude();
      if (bad_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end
   task chk(input string nm, input logic [135:0] e, input logic [135:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin @(posedge clk); end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Idle edge so a following request never overlaps this release
      @(posedge clk);
   endtask : bus
   // Silent drops need a fixed quiet window
   task wait_got(input int k);
      n = 0;
      while ((k > 0 ? i_host.got.size() < k : n < 60) && n < 400) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_got
   task tick(input logic lvl);
      sec_tick <= 1'b1;
      @(posedge clk);
      sec_tick <= 1'b0;
      n = 0;
      repeat (30) @(posedge clk) if (pulse_out === lvl) n++;
   endtask : tick
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int r = 0; r < 8; r++) begin
         i_host.slow <= r[0];
         i_host.got.delete();
         i_host.build(md[r][7:0], ub[r] ? CFG_B : CFG_A);
         if (ci[r] != 0) i_host.pk[ci[r]] ^= 8'h01;
         ok = ci[r] == 0 && md[r] < 2;
         if (ok && md[r] == 1) cur = CFG_A;
         i_host.send_pkt();
         wait_got(ok ? 26 : 0);
         i_host.build(8'h02, cur);
         chk("reply count", ok ? 26 : 0, i_host.got.size());
         for (int i = 0; ok && i < 26; i++)
            chk("tx byte", i_host.pk[i], i_host.got[i]);
         chk("cfg_out", cur, cfg_out);
      end
      chk("time base", {CFG_A.time_base[2:0], CFG_A.time_base[3]}, time_base_sel);
      chk("pulse base", {3'h2, 1'b0}, pulse_base_sel);
      bus(1'b0, 8'h08, 32'h0000_0000);
      chk("cfg reg", 32'h000B_0209, q);
      bus(1'b0, 8'h10, 32'h0000_0000);
      chk("offset hi", 32'h3FF0_0000, q);
      bus(1'b0, 8'h20, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, q);
      bus(1'b1, 8'h00, 32'h0000_0000);
      i_host.got.delete();
      i_host.build(8'h00, cur);
      i_host.send_pkt();
      wait_got(0);
      chk("disabled reply", 0, i_host.got.size());
      bus(1'b1, 8'h00, 32'h0000_0001);
      // Bytes held while disabled are parsed once enabled again
      wait_got(26);
      chk("held reply", 26, i_host.got.size());
      chk("pulse idle", 1'b1, pulse_out);
      tick(1'b0);
      chk("pulse width", 8, n);
      i_host.got.delete();
      i_host.build(8'h01, CFG_C);
      cur = CFG_C;
      i_host.send_pkt();
      wait_got(26);
      chk("set reply", 26, i_host.got.size());
      chk("pulse idle low", 1'b0, pulse_out);
      fix_valid <= 1'b1;
      tick(1'b1);
      chk("pulse gated", 0, n);
      timing_valid <= 1'b1;
      tick(1'b1);
      chk("pulse valid", 4, n);
      // Response stalled: parser stops, FIFO fills to its depth
      i_host.got.delete();
      i_host.hold <= 1'b1;
      i_host.build(8'h00, cur);
      i_host.send_pkt();
      n = 0;
      while (tx_valid !== 1'b1 && n < 100) begin @(posedge clk); n++; end
      i_host.build(8'h00, cur);
      repeat (7) i_host.pk.push_back(8'h00);
      i_host.send_pkt();
      #1 chk("fifo full", 1'b0, rx_ready);
      i_host.hold <= 1'b0;
      wait_got(52);
      i_host.build(8'h02, cur);
      for (int i = 0; i < 52; i++)
         chk("queued reply", i_host.pk[i % 26], i_host.got[i]);
      bus(1'b0, 8'h18, 32'h0000_0000);
      chk("good count", 7, q);
      bus(1'b0, 8'h1C, 32'h0000_0000);
      chk("drop count", 9, q);
      chk("cfg_updated", 2, upd_count);
      // Lane 0 disabled: enable bit must survive
      be <= 4'hE;
      bus(1'b1, 8'h00, 32'h0000_0000);
      bus(1'b0, 8'h00, 32'h0000_0000);
      chk("ctrl lane", 32'h0000_0001, q);
      // Mid-run reset clears configuration, stream and counters
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      chk("reset cfg", 0, cfg_out);
      chk("reset tx", 1'b0, tx_valid);
      chk("reset ready", 1'b1, rx_ready);
      resetn <= 1'b1;
      @(posedge clk);
      bus(1'b0, 8'h18, 32'h0000_0000);
      chk("reset good", 0, q);
      conclude();
   end
endmodule : timing_config_packet_handler_tb
